// >>> pkg/rps_regs.vh
// register offsets, field positions and timing constants for the status pin mux
// assumes nothing; definitions only
`ifndef RPS_REGS_VH
`define RPS_REGS_VH
// ==========================================================
// subaddresses
`define RPS_ADDR_FMT_DELAY 8'h10
`define RPS_ADDR_OUT_CTRL 8'h11
`define RPS_ADDR_PIN_SEL 8'h12
`define RPS_ADDR_FID_CTRL 8'h13
`define RPS_ADDR_VWIN_START_LO 8'h15
`define RPS_ADDR_VWIN_STOP_LO 8'h16
`define RPS_ADDR_VWIN_MSB 8'h17
`define RPS_ADDR_HPULSE_BEGIN 8'h06
`define RPS_ADDR_HPULSE_STOP 8'h07
// ==========================================================
// field positions
`define RPS_BIT_DECODER_BYPASS 1
`define RPS_BIT_RT_OUT_ENABLE 2
`define RPS_BIT_LOCK_SPEED 4
`define RPS_BIT_GEN_SWITCH 5
`define RPS_BIT_VREF_LENGTH 3
`define RPS_BIT_FID_POLARITY 3
`define RPS_BIT_VSTART_MSB 0
`define RPS_BIT_VSTOP_MSB 1
`define RPS_FDEL_HI 5
`define RPS_FDEL_LO 4
// ==========================================================
// reset values
`define RPS_RST_BYTE 8'h00
// ==========================================================
// selector codes
`define RPS_SEL_RESERVED 4'h0
`define RPS_SEL_ADC_LSB 4'h1
`define RPS_SEL_SWITCH 4'h2
`define RPS_SEL_HLOCK 4'h3
`define RPS_SEL_VHLOCK 4'h4
`define RPS_SEL_CLOCK 4'h5
`define RPS_SEL_PALSEQ 4'h6
`define RPS_SEL_LINE_VALID_REF 4'h7
`define RPS_SEL_HSYNC 4'h8
`define RPS_SEL_HQ 4'h9
`define RPS_SEL_ODD 4'ha
`define RPS_SEL_VSYNC 4'hb
`define RPS_SEL_VALT 4'hc
`define RPS_SEL_VERTICAL_WINDOW_GATE 4'hd
`define RPS_SEL_VREF 4'he
`define RPS_SEL_FID 4'hf
// ==========================================================
// timing
`define RPS_LINE_VALID_REF_HIGH_CLKS 12'd1440
`define RPS_LINE_TYPE_RAW 4'h7
`endif

// >>> rtl/rps_hpulse.v
// programmable horizontal pulse window in eight-clock steps with a fine delay
// assumes line_start_in pulses once per line on the line-locked clock
`timescale 1ns/100ps
module rps_hpulse #(
  parameter CW = 12
) (
  input wire mclk_in,
  input wire rst_n_in,
  input wire line_start_in,
  input wire [7:0] begin_in,
  input wire [7:0] stop_in,
  input wire [2:0] fine_in,
  output reg pulse_out
);
  // ==========================================================
  // line position counter
  reg [CW-1:0] pos_r;
  wire [CW-1:0] pos_nxt;
  wire [CW-1:0] beg_pos;
  wire [CW-1:0] end_pos;
  assign pos_nxt = line_start_in ? {CW{1'b0}} : pos_r + {{(CW-1){1'b0}}, 1'b1};
  assign beg_pos = {{(CW-11){1'b0}}, begin_in, 3'h0} + {{(CW-3){1'b0}}, fine_in};
  assign end_pos = {{(CW-11){1'b0}}, stop_in, 3'h0} + {{(CW-3){1'b0}}, fine_in};
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pos_r <= {CW{1'b0}};
      pulse_out <= 1'b0;
    end else begin
      pos_r <= pos_nxt;
      if (pos_nxt == beg_pos)
        pulse_out <= 1'b1;
      // a pulse still high at the next line start is cut there unless the window begins at 0, so a stale
      // window left over from earlier settings never stretches the new one
      else if ((pos_nxt == end_pos) || line_start_in)
        pulse_out <= 1'b0;
    end
  end
endmodule // rps_hpulse

// >>> rtl/rps_status_pin.v
// first real-time status pin source multiplexer with its control bytes
// Overview of operation
// - low nibble of byte 12h picks pin source
// - code 1 gives converter lsbs under bypass
// - code 2 drives general switch level
// - code 3 gives horizontal lock, speed selectable
// - codes 4, 5 give lock and colour locks
// - code 6 gives pal sequence, low on pal
// - code 7 gives horizontal line reference
// - reference high 1440 clocks for normal types
// - raw type uses programmable begin and stop
// - code 8 gives programmable horizontal sync
// - code 9 gates line reference with vertical
// - code 10 gives odd field high
// - codes 11, 12 give vertical pulses
// - code 13 gives programmable vertical gate
// - code 14 gives vertical reference, two positions
// - code 15 gives field id, programmable position
// - pin floats while realtime enable is low
// - switch bit sets pin low or high
// assumes byte writes arrive as a one-cycle strobe with address and data,
// and that timing sources are synchronous to the line-locked clock
`include "rps_regs.vh"
`timescale 1ns/100ps
module rps_status_pin #(
  parameter LINE_W = 9,
  parameter CW = 12
) (
  input wire mclk_in,
  input wire rst_n_in,
  input wire reg_wr_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  input wire adc_lsb_in,
  input wire hlock_std_in,
  input wire hlock_fast_in,
  input wire vlock_in,
  input wire colour_in,
  input wire pal_line_in,
  input wire line_start_in,
  input wire [3:0] line_type_in,
  input wire vref_a_in,
  input wire vref_b_in,
  input wire odd_field_in,
  input wire vsync_in,
  input wire valt_in,
  input wire [LINE_W-1:0] line_num_in,
  input wire status_pin_first_in,
  output reg status_pin_first_out,
  output wire status_pin_first_oe_n_out
);
  // ==========================================================
  // control bytes
  reg [7:0] pin_sel_r;
  reg [7:0] out_ctrl_r;
  reg [7:0] fmt_delay_r;
  reg [7:0] fid_ctrl_r;
  reg [7:0] hbegin_r;
  reg [7:0] hstop_r;
  reg [7:0] vstart_lo_r;
  reg [7:0] vstop_lo_r;
  reg [7:0] vmsb_r;

  // ==========================================================
  // write decode, one strobe per control byte
  wire wr_pin_sel;
  wire wr_out_ctrl;
  wire wr_fmt_delay;
  wire wr_fid_ctrl;
  wire wr_hbegin;
  wire wr_hstop;
  wire wr_vstart_lo;
  wire wr_vstop_lo;
  wire wr_vmsb;
  assign wr_pin_sel = reg_wr_in && (reg_addr_in == `RPS_ADDR_PIN_SEL);
  assign wr_out_ctrl = reg_wr_in && (reg_addr_in == `RPS_ADDR_OUT_CTRL);
  assign wr_fmt_delay = reg_wr_in && (reg_addr_in == `RPS_ADDR_FMT_DELAY);
  assign wr_fid_ctrl = reg_wr_in && (reg_addr_in == `RPS_ADDR_FID_CTRL);
  assign wr_hbegin = reg_wr_in && (reg_addr_in == `RPS_ADDR_HPULSE_BEGIN);
  assign wr_hstop = reg_wr_in && (reg_addr_in == `RPS_ADDR_HPULSE_STOP);
  assign wr_vstart_lo = reg_wr_in && (reg_addr_in == `RPS_ADDR_VWIN_START_LO);
  assign wr_vstop_lo = reg_wr_in && (reg_addr_in == `RPS_ADDR_VWIN_STOP_LO);
  assign wr_vmsb = reg_wr_in && (reg_addr_in == `RPS_ADDR_VWIN_MSB);
  // unmapped subaddresses raise no strobe and are ignored

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pin_sel_r <= `RPS_RST_BYTE;
    end else if (wr_pin_sel) begin
      pin_sel_r <= reg_wdata_in;
    end
  end

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      out_ctrl_r <= `RPS_RST_BYTE;
    end else if (wr_out_ctrl) begin
      out_ctrl_r <= reg_wdata_in;
    end
  end

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      fmt_delay_r <= `RPS_RST_BYTE;
    end else if (wr_fmt_delay) begin
      fmt_delay_r <= reg_wdata_in;
    end
  end

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      fid_ctrl_r <= `RPS_RST_BYTE;
    end else if (wr_fid_ctrl) begin
      fid_ctrl_r <= reg_wdata_in;
    end
  end

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      hbegin_r <= `RPS_RST_BYTE;
    end else if (wr_hbegin) begin
      hbegin_r <= reg_wdata_in;
    end
  end

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      hstop_r <= `RPS_RST_BYTE;
    end else if (wr_hstop) begin
      hstop_r <= reg_wdata_in;
    end
  end

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      vstart_lo_r <= `RPS_RST_BYTE;
    end else if (wr_vstart_lo) begin
      vstart_lo_r <= reg_wdata_in;
    end
  end

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      vstop_lo_r <= `RPS_RST_BYTE;
    end else if (wr_vstop_lo) begin
      vstop_lo_r <= reg_wdata_in;
    end
  end

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      vmsb_r <= `RPS_RST_BYTE;
    end else if (wr_vmsb) begin
      vmsb_r <= reg_wdata_in;
    end
  end

  // ==========================================================
  // readback
  reg [7:0] rdata_nxt;
  always @* begin
    case (reg_addr_in)
      `RPS_ADDR_PIN_SEL: rdata_nxt = pin_sel_r;
      `RPS_ADDR_OUT_CTRL: rdata_nxt = out_ctrl_r;
      `RPS_ADDR_FMT_DELAY: rdata_nxt = fmt_delay_r;
      `RPS_ADDR_FID_CTRL: rdata_nxt = fid_ctrl_r;
      `RPS_ADDR_HPULSE_BEGIN: rdata_nxt = hbegin_r;
      `RPS_ADDR_HPULSE_STOP: rdata_nxt = hstop_r;
      `RPS_ADDR_VWIN_START_LO: rdata_nxt = vstart_lo_r;
      `RPS_ADDR_VWIN_STOP_LO: rdata_nxt = vstop_lo_r;
      `RPS_ADDR_VWIN_MSB: rdata_nxt = vmsb_r;
      default: rdata_nxt = 8'h00;
    endcase
  end
  always @(posedge mclk_in) begin
    if (!rst_n_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
      reg_rdata_out <= rdata_nxt;
  end

  // ==========================================================
  // field decode
  wire [3:0] pin_first_source_sel;
  wire decoder_bypass;
  wire realtime_output_enable;
  wire lock_speed_select;
  wire general_switch_first;
  wire vertical_ref_length;
  wire field_ident_polarity;
  wire [1:0] horiz_fine_delay;
  wire [LINE_W-1:0] vertical_window_start;
  wire [LINE_W-1:0] vertical_window_stop;
  assign pin_first_source_sel = pin_sel_r[3:0];
  assign decoder_bypass = out_ctrl_r[`RPS_BIT_DECODER_BYPASS];
  assign realtime_output_enable = out_ctrl_r[`RPS_BIT_RT_OUT_ENABLE];
  assign lock_speed_select = out_ctrl_r[`RPS_BIT_LOCK_SPEED];
  assign general_switch_first = out_ctrl_r[`RPS_BIT_GEN_SWITCH];
  assign vertical_ref_length = fmt_delay_r[`RPS_BIT_VREF_LENGTH];
  assign field_ident_polarity = fid_ctrl_r[`RPS_BIT_FID_POLARITY];
  assign horiz_fine_delay = fmt_delay_r[`RPS_FDEL_HI:`RPS_FDEL_LO];
  assign vertical_window_start = {vmsb_r[`RPS_BIT_VSTART_MSB], vstart_lo_r};
  assign vertical_window_stop = {vmsb_r[`RPS_BIT_VSTOP_MSB], vstop_lo_r};

  // ==========================================================
  // horizontal pulse generators
  wire horizontal_sync_pulse;
  wire raw_line_valid_ref;
  rps_hpulse #(.CW(CW)) u_hsync (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .line_start_in(line_start_in),
    .begin_in(hbegin_r),
    .stop_in(hstop_r),
    .fine_in({horiz_fine_delay, 1'b0}),
    .pulse_out(horizontal_sync_pulse)
  );
  rps_hpulse #(.CW(CW)) u_rawref (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .line_start_in(line_start_in),
    .begin_in(hbegin_r),
    .stop_in(hstop_r),
    .fine_in({horiz_fine_delay, 1'b0}),
    .pulse_out(raw_line_valid_ref)
  );

  // ==========================================================
  // fixed 1440-clock active line for all other data types
  reg [CW-1:0] line_valid_ref_cnt_r;
  reg std_line_valid_ref_r;
  wire line_valid_ref_cnt_zero;
  assign line_valid_ref_cnt_zero = (line_valid_ref_cnt_r == {CW{1'b0}});

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      line_valid_ref_cnt_r <= {CW{1'b0}};
    end else if (line_start_in) begin
      line_valid_ref_cnt_r <= `RPS_LINE_VALID_REF_HIGH_CLKS - 12'd1;
    end else if (!line_valid_ref_cnt_zero) begin
      line_valid_ref_cnt_r <= line_valid_ref_cnt_r - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      std_line_valid_ref_r <= 1'b0;
    end else if (line_start_in) begin
      std_line_valid_ref_r <= 1'b1;
    end else if (line_valid_ref_cnt_zero) begin
      std_line_valid_ref_r <= 1'b0;
    end
  end

  wire line_valid_ref;
  assign line_valid_ref = (line_type_in == `RPS_LINE_TYPE_RAW) ? raw_line_valid_ref : std_line_valid_ref_r;

  // ==========================================================
  // vertical sources
  wire vref_sel;
  wire vertical_window_gate;
  wire gated_line_ref;
  wire field_ident_out;
  reg fid_r;
  assign vref_sel = vertical_ref_length ? vref_b_in : vref_a_in;
  wire past_window_start;
  wire before_window_stop;
  wire fid_latch_line;
  assign past_window_start = (line_num_in >= vertical_window_start);
  assign before_window_stop = (line_num_in < vertical_window_stop);
  assign vertical_window_gate = past_window_start & before_window_stop;
  assign gated_line_ref = line_valid_ref & vref_sel;
  assign fid_latch_line = (line_num_in == vertical_window_start);

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      fid_r <= 1'b0;
    end else if (fid_latch_line) begin
      fid_r <= odd_field_in;
    end
  end
  assign field_ident_out = fid_r ^ field_ident_polarity;

  // ==========================================================
  // lock, sequence and vertical pulse flags
  wire horiz_lock_flag;
  wire both_lock_flag;
  wire colour_lock_flag;
  wire pal_sequence_flag;
  wire adc_lsb_gated;
  wire vertical_sync_pulse;
  wire vertical_pulse_alt;
  assign horiz_lock_flag = lock_speed_select ? hlock_fast_in : hlock_std_in;
  assign both_lock_flag = vlock_in & hlock_std_in;
  assign colour_lock_flag = both_lock_flag & colour_in;
  assign pal_sequence_flag = ~pal_line_in;
  assign adc_lsb_gated = decoder_bypass & adc_lsb_in;
  assign vertical_sync_pulse = vsync_in;
  assign vertical_pulse_alt = valt_in;

  // ==========================================================
  // source multiplexer, registered so a selector change cannot glitch the pin
  reg pin_nxt;
  always @* begin
    case (pin_first_source_sel)
      `RPS_SEL_ADC_LSB: pin_nxt = adc_lsb_gated;
      `RPS_SEL_SWITCH: pin_nxt = general_switch_first;
      `RPS_SEL_HLOCK: pin_nxt = horiz_lock_flag;
      `RPS_SEL_VHLOCK: pin_nxt = both_lock_flag;
      `RPS_SEL_CLOCK: pin_nxt = colour_lock_flag;
      `RPS_SEL_PALSEQ: pin_nxt = pal_sequence_flag;
      `RPS_SEL_LINE_VALID_REF: pin_nxt = line_valid_ref;
      `RPS_SEL_HSYNC: pin_nxt = horizontal_sync_pulse;
      `RPS_SEL_HQ: pin_nxt = gated_line_ref;
      `RPS_SEL_ODD: pin_nxt = odd_field_in;
      `RPS_SEL_VSYNC: pin_nxt = vertical_sync_pulse;
      `RPS_SEL_VALT: pin_nxt = vertical_pulse_alt;
      `RPS_SEL_VERTICAL_WINDOW_GATE: pin_nxt = vertical_window_gate;
      `RPS_SEL_VREF: pin_nxt = vref_sel;
      `RPS_SEL_FID: pin_nxt = field_ident_out;
      default: pin_nxt = 1'b0;
    endcase
  end

  // ==========================================================
  // pin drive stage
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      status_pin_first_out <= 1'b0;
    end else begin
      status_pin_first_out <= pin_nxt;
    end
  end

  // ==========================================================
  // output enable
  // pin input is unused: with the enable low the pin only floats
  assign status_pin_first_oe_n_out = ~realtime_output_enable;
endmodule // rps_status_pin

// >>> dv/rps_status_pin_properties.sv
// concurrent checks on the status pin mux ports
// assumes sync active-low reset and one-cycle register write strobes
`timescale 1ns/100ps
module rps_status_pin_props (
  input wire mclk_in,
  input wire rst_n_in,
  input wire reg_wr_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire adc_lsb_in,
  input wire hlock_std_in,
  input wire hlock_fast_in,
  input wire vlock_in,
  input wire colour_in,
  input wire pal_line_in,
  input wire odd_field_in,
  input wire vsync_in,
  input wire valt_in,
  input wire status_pin_first_out,
  input wire status_pin_first_oe_n_out
);
  // ==========================================================
  // shadow of the control and selector bytes
  logic [7:0] ctl_r;
  logic [3:0] sel_r;
  wire pin = status_pin_first_out;
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ctl_r <= 8'h00;
      sel_r <= 4'h0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == 8'h11) ctl_r <= reg_wdata_in;
      if (reg_addr_in == 8'h12) sel_r <= reg_wdata_in[3:0];
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================
  // assertions
  property p_oe; status_pin_first_oe_n_out != ctl_r[2]; endproperty
  a_oe: assert property (p_oe) else $error("pin enable mismatch");
  property p_rsv; sel_r == 4'h0 |=> !pin; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code not low");
  property p_adc; sel_r == 4'h1 |=> pin == $past(ctl_r[1] & adc_lsb_in); endproperty
  a_adc: assert property (p_adc) else $error("converter lsb mismatch");
  property p_sw; sel_r == 4'h2 |=> pin == $past(ctl_r[5]); endproperty
  a_sw: assert property (p_sw) else $error("switch level mismatch");
  property p_hl;
    sel_r == 4'h3 |=> pin == $past(ctl_r[4] ? hlock_fast_in : hlock_std_in);
  endproperty
  a_hl: assert property (p_hl) else $error("lock flag mismatch");
  property p_lock;
    sel_r[3:1] == 3'b010 |=>
      pin == $past(vlock_in & hlock_std_in & (colour_in | !sel_r[0]));
  endproperty
  a_lock: assert property (p_lock) else $error("lock combination mismatch");
  property p_pal; sel_r == 4'h6 && pal_line_in |=> !pin; endproperty
  a_pal: assert property (p_pal) else $error("sequence flag not low");
  property p_odd; sel_r == 4'ha |=> pin == $past(odd_field_in); endproperty
  a_odd: assert property (p_odd) else $error("field flag mismatch");
  property p_vs; sel_r == 4'hb |=> pin == $past(vsync_in); endproperty
  a_vs: assert property (p_vs) else $error("vertical sync mismatch");
  property p_va; (sel_r == 4'hc) [*2] |-> pin == $past(valt_in); endproperty
  a_va: assert property (p_va) else $error("vertical pulse mismatch");
  c_sw: cover property (sel_r == 4'h2 ##1 pin);
  c_lock: cover property (sel_r == 4'h5 ##1 pin);
  c_en: cover property ($fell(status_pin_first_oe_n_out));
endmodule // rps_status_pin_props

bind rps_status_pin rps_status_pin_props u_props (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .adc_lsb_in(adc_lsb_in), .hlock_std_in(hlock_std_in), .hlock_fast_in(hlock_fast_in),
  .vlock_in(vlock_in), .colour_in(colour_in), .pal_line_in(pal_line_in),
  .odd_field_in(odd_field_in), .vsync_in(vsync_in), .valt_in(valt_in),
  .status_pin_first_out(status_pin_first_out),
  .status_pin_first_oe_n_out(status_pin_first_oe_n_out));

// >>> dv/rps_pin_capture.sv
// model of the capture logic that samples the status pin
// assumes the pin output enable is active low
`timescale 1ns/100ps
module rps_pin_capture (
  input wire mclk_in,
  input wire pin_in,
  input wire oe_n_in,
  output wire level_out,
  output reg sample_out
);
  reg last_r = 1'b0;
  // a released pin shows the inverse of its last driven level
  assign level_out = oe_n_in ? !last_r : pin_in;
  always @(posedge mclk_in) begin
    if (!oe_n_in) last_r <= pin_in;
    sample_out <= level_out;
  end
endmodule // rps_pin_capture

// >>> dv/tb.sv
// self-checking bench for the status pin mux
// assumes a 125 MHz line-locked clock and a partner that samples the pin
`timescale 1ns/100ps
module tb;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [10:0] src = 11'h000;
  logic line_start_in = 1'b0;
  logic [3:0] line_type_in = 4'h0;
  logic [8:0] line_num_in = 9'h000;
  wire [7:0] reg_rdata_out;
  wire pin_out;
  wire oe_n_out;
  wire level;
  int failures = 0;
  int compares = 0;
  int n;
  // ==========================================================
  // rows: selector, control byte 11h, sources, expected level
  localparam logic [23:0] ROWS [18] = '{
    {4'h0, 8'h04, 11'h7ff, 1'b0},
    {4'h1, 8'h04, 11'h7ff, 1'b0},
    {4'h1, 8'h06, 11'h400, 1'b1},
    {4'h2, 8'h24, 11'h000, 1'b1},
    {4'h2, 8'h04, 11'h7ff, 1'b0},
    {4'h3, 8'h04, 11'h200, 1'b1},
    {4'h3, 8'h14, 11'h200, 1'b0},
    {4'h4, 8'h04, 11'h280, 1'b1},
    {4'h5, 8'h04, 11'h280, 1'b0},
    {4'h5, 8'h04, 11'h2c0, 1'b1},
    {4'h6, 8'h04, 11'h020, 1'b0},
    {4'h6, 8'h04, 11'h000, 1'b1},
    {4'ha, 8'h04, 11'h004, 1'b1},
    {4'hb, 8'h04, 11'h002, 1'b1},
    {4'hc, 8'h04, 11'h001, 1'b1},
    {4'he, 8'h04, 11'h010, 1'b1},
    {4'h9, 8'h04, 11'h010, 1'b0},
    {4'hf, 8'h04, 11'h004, 1'b1}};
  initial forever #4 mclk_in = ~mclk_in;
  rps_status_pin u_rps_status_pin (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .adc_lsb_in(src[10]),
    .hlock_std_in(src[9]), .hlock_fast_in(src[8]), .vlock_in(src[7]), .colour_in(src[6]),
    .pal_line_in(src[5]), .line_start_in(line_start_in), .line_type_in(line_type_in),
    .vref_a_in(src[4]), .vref_b_in(src[3]), .odd_field_in(src[2]), .vsync_in(src[1]),
    .valt_in(src[0]), .line_num_in(line_num_in), .status_pin_first_in(level),
    .status_pin_first_out(pin_out), .status_pin_first_oe_n_out(oe_n_out));
  rps_pin_capture u_rps_pin_capture (.mclk_in(mclk_in), .pin_in(pin_out),
    .oe_n_in(oe_n_out), .level_out(level), .sample_out());
  task automatic tick(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic r, input logic [7:0] a, input logic [7:0] d);
    reg_rd_in = r;
    reg_wr_in = !r;
    reg_addr_in = a;
    reg_wdata_in = d;
    tick(1);
    reg_rd_in = 1'b0;
    reg_wr_in = 1'b0;
    tick(1);
  endtask
  // counts high cycles of the pin after one line start
  task automatic line_hi(input int exp);
    line_start_in = 1'b1;
    tick(1);
    line_start_in = 1'b0;
    n = 0;
    repeat (1600) begin
      tick(1);
      n += (level === 1'b1);
    end
    chk(n, exp);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    tick(12);
    rst_n_in = 1'b1;
    bus(1'b1, 8'h12, 8'h00);
    chk(reg_rdata_out, 8'h00);
    chk(oe_n_out, 1'b1);
    $display("reset test done");
    foreach (ROWS[i]) begin
      bus(1'b0, 8'h11, ROWS[i][19:12]);
      bus(1'b0, 8'h12, {4'h0, ROWS[i][23:20]});
      src = ROWS[i][11:1];
      tick(2);
      chk(level, ROWS[i][0]);
      chk(oe_n_out, 1'b0);
    end
    $display("table test done");
    bus(1'b0, 8'h12, 8'h5a);
    bus(1'b1, 8'h12, 8'h00);
    chk(reg_rdata_out, 8'h5a);
    bus(1'b1, 8'h20, 8'h00);
    chk(reg_rdata_out, 8'h00);
    $display("register test done");
    src = 11'h000;
    bus(1'b0, 8'h12, 8'h07);
    line_hi(1440);
    bus(1'b0, 8'h06, 8'h02);
    bus(1'b0, 8'h07, 8'h04);
    line_type_in = 4'h7;
    line_hi(16);
    bus(1'b0, 8'h12, 8'h08);
    line_hi(16);
    $display("line test done");
    bus(1'b0, 8'h15, 8'h05);
    bus(1'b0, 8'h16, 8'h08);
    bus(1'b0, 8'h12, 8'h0d);
    for (int k = 3; k < 10; k++) begin
      line_num_in = 9'(k);
      tick(2);
      chk(level, (k >= 5 && k < 8));
    end
    bus(1'b0, 8'h11, 8'h00);
    chk(oe_n_out, 1'b1);
    $display("gate test done");
    tally_and_finish();
  end
endmodule // tb
